// ==== design/asp_top.sv ====
// Asynchronous serial transceiver with queues, flow control and diagnostics
// Operation
// - Converts between serial bits and parallel characters.
// - Baud divisor 1 to 65535 sets bit timing.
// - Five to eight data bits, both directions.
// - Even, odd or no parity; sent and checked.
// - One, one and a half or two stop bits.
// - Separate sixteen-byte transmit and receive queues.
// - Queues may be bypassed for single-character holding.
// - Receive threshold of 1, 4, 8 or 14 bytes.
// - Separate DMA requests for receive data and transmit space.
// - Receive and transmit interrupts, each individually enabled.
// - Start bit high at mid-bit is noise.
// - Transmit break on command; receiver flags break.
// - Loopback feeds transmit output to the receiver.
// - Software forces break, parity, overrun and framing flags.
// - Autoflow: hold transmit while CTS inactive; RTS inactive at threshold.
// - Fastest bit rate is clock over sixteen.
// - Start and data bits each last one baud period.
`timescale 1ns/1ps
module asp_top
    import asp_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic MCLK_I,
    input wire logic RESET_I,
    input wire logic [ADDR_W-1:0] ADDR_I,
    input wire logic [REG_W-1:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [REG_W-1:0] RDATA_O,
    input wire logic RXD_I,
    output logic TXD_O,
    input wire logic CTS_N_I,
    output logic RTS_N_O,
    output logic IRQ_O,
    output logic RX_DMA_REQ_O,
    output logic TX_DMA_REQ_O
);
    localparam int CW = $clog2(DEPTH + 1);

    if (DEPTH < 16) begin : g_chk
        $error("asp_top: DEPTH must hold at least 16 characters");
    end

    // ====
    // Helpers
    function automatic logic par_bit(input logic [7:0] d, input logic even);
        return even ? ^d : ~^d;
    endfunction : par_bit

    // Bits enter at the top; short characters shift right
    function automatic logic [7:0] align(input logic [7:0] sh, input logic [1:0] len);
        return sh >> (2'd3 - len);
    endfunction : align

    function automatic logic [CW-1:0] trig_level(input logic [1:0] sel, input logic fen);
        logic [4:0] t;
        t = TRIG_1;
        if (fen) begin
            unique case (sel)
                2'd0: t = TRIG_1;
                2'd1: t = TRIG_4;
                2'd2: t = TRIG_8;
                2'd3: t = TRIG_14;
            endcase
        end
        return CW'(t);
    endfunction : trig_level

    // ====
    // Registers
    logic [REG_W-1:0] div_q;
    logic [CFG_W-1:0] cfg_q;
    logic [ST_W-1:0] stat_q;
    logic [ST_W-1:0] stat_d;
    logic [ST_W-1:0] mask_q;
    logic [REG_W-1:0] rdata_q;
    logic irq_q;
    logic rts_n_q;
    logic rx_dma_q;
    logic tx_dma_q;
    logic txo_q;

    wire [1:0] len = cfg_q[CFG_LEN_LO+:2];
    wire [2:0] nbit_m1 = {1'b1, len};
    wire pen = cfg_q[CFG_PEN];
    wire even = cfg_q[CFG_EVEN];
    wire fen = cfg_q[CFG_FIFO];
    wire afc = cfg_q[CFG_AFC];
    wire loop = cfg_q[CFG_LOOP];
    wire [CW-1:0] lim = fen ? CW'(DEPTH) : CW'(1);
    wire [CW-1:0] trig = trig_level(cfg_q[CFG_TRIG_LO+:2], fen);

    wire wr_data = WR_I && (ADDR_I == OFS_DATA);
    wire wr_div = WR_I && (ADDR_I == OFS_DIV);
    wire wr_cfg = WR_I && (ADDR_I == OFS_CFG);
    wire wr_stat = WR_I && (ADDR_I == OFS_STAT);
    wire wr_mask = WR_I && (ADDR_I == OFS_MASK);
    wire wr_diag = WR_I && (ADDR_I == OFS_DIAG);
    wire rd_data = RD_I && (ADDR_I == OFS_DATA);

    // ====
    // Pin synchronisers
    logic rxd_s1_q;
    logic rxd_s2_q;
    logic cts_s1_q;
    logic cts_s2_q;
    always_ff @(posedge MCLK_I) begin
        if (RESET_I) begin
            rxd_s1_q <= 1'b1;
            rxd_s2_q <= 1'b1;
            cts_s1_q <= 1'b1;
            cts_s2_q <= 1'b1;
        end else begin
            rxd_s1_q <= RXD_I;
            rxd_s2_q <= rxd_s1_q;
            cts_s1_q <= CTS_N_I;
            cts_s2_q <= cts_s1_q;
        end
    end

    // ====
    // Baud tick, one per sixteenth of a bit
    logic [REG_W-1:0] div_cnt_q;
    // Divisor zero runs as one
    wire [REG_W-1:0] div_eff = (div_q == '0) ? DIV_RST : div_q;
    wire tick = div_cnt_q >= (div_eff - DIV_RST);
    always_ff @(posedge MCLK_I) begin
        if (RESET_I || tick) begin
            div_cnt_q <= '0;
        end else begin
            div_cnt_q <= div_cnt_q + DIV_RST;
        end
    end

    // ====
    // Queues
    logic txf_ready;
    logic txf_valid;
    logic [7:0] txf_data;
    logic [CW-1:0] tx_cnt;
    logic tx_pop;
    logic rxf_ready;
    logic rxf_valid;
    logic [7:0] rxf_data;
    logic [CW-1:0] rx_cnt;
    logic rx_push;
    logic [7:0] rx_char;

    asp_fifo #(.W(DATA_W), .DEPTH(DEPTH)) u_txq (
        .clk_i(MCLK_I),
        .rst_i(RESET_I),
        .lim_i(lim),
        .in_valid_i(wr_data),
        .in_ready_o(txf_ready),
        .in_data_i(WDATA_I[7:0]),
        .out_valid_o(txf_valid),
        .out_ready_i(tx_pop),
        .out_data_o(txf_data),
        .count_o(tx_cnt)
    );

    asp_fifo #(.W(DATA_W), .DEPTH(DEPTH)) u_rxq (
        .clk_i(MCLK_I),
        .rst_i(RESET_I),
        .lim_i(lim),
        .in_valid_i(rx_push),
        .in_ready_o(rxf_ready),
        .in_data_i(rx_char),
        .out_valid_o(rxf_valid),
        .out_ready_i(rd_data),
        .out_data_o(rxf_data),
        .count_o(rx_cnt)
    );

    // ====
    // Transmitter
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} asp_tx_e;
    asp_tx_e tx_st_q;
    asp_tx_e tx_st_d;
    logic [4:0] tx_ph_q;
    logic [4:0] tx_ph_d;
    logic [2:0] tx_bit_q;
    logic [2:0] tx_bit_d;
    logic [7:0] tx_sh_q;
    logic [7:0] tx_sh_d;
    logic tx_par_q;
    logic tx_par_d;
    logic txd_d;
    logic line_q;

    wire flow_ok = !afc || !cts_s2_q;
    wire [4:0] stop_last = !cfg_q[CFG_STOP2] ? STOP1_LAST :
                           (len == 2'd0) ? STOP15_LAST : STOP2_LAST;
    wire tx_end = tick && (tx_ph_q == {1'b0, END_PH});

    always_comb begin
        tx_st_d = tx_st_q;
        tx_ph_d = tick ? tx_ph_q + 5'h01 : tx_ph_q;
        tx_bit_d = tx_bit_q;
        tx_sh_d = tx_sh_q;
        tx_par_d = tx_par_q;
        tx_pop = 1'b0;
        txd_d = 1'b1;
        unique case (tx_st_q)
            TX_IDLE: begin
                tx_ph_d = '0;
                // Start on a tick so every bit is sixteen ticks
                if (tick && txf_valid && flow_ok) begin
                    tx_pop = 1'b1;
                    tx_sh_d = txf_data;
                    tx_par_d = par_bit(txf_data & (8'hFF >> (2'd3 - len)), even);
                    tx_bit_d = '0;
                    tx_st_d = TX_START;
                end
            end
            TX_START: begin
                txd_d = 1'b0;
                if (tx_end) begin
                    tx_ph_d = '0;
                    tx_st_d = TX_DATA;
                end
            end
            TX_DATA: begin
                txd_d = tx_sh_q[0];
                if (tx_end) begin
                    tx_ph_d = '0;
                    tx_sh_d = {1'b0, tx_sh_q[7:1]};
                    tx_bit_d = tx_bit_q + 3'd1;
                    if (tx_bit_q == nbit_m1) begin
                        tx_st_d = pen ? TX_PAR : TX_STOP;
                    end
                end
            end
            TX_PAR: begin
                txd_d = tx_par_q;
                if (tx_end) begin
                    tx_ph_d = '0;
                    tx_st_d = TX_STOP;
                end
            end
            TX_STOP: begin
                if (tick && (tx_ph_q == stop_last)) begin
                    tx_ph_d = '0;
                    tx_st_d = TX_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge MCLK_I) begin
        if (RESET_I) begin
            tx_st_q <= TX_IDLE;
            tx_ph_q <= '0;
            tx_bit_q <= '0;
            tx_sh_q <= '0;
            tx_par_q <= 1'b0;
            line_q <= 1'b1;
            txo_q <= 1'b1;
        end else begin
            tx_st_q <= tx_st_d;
            tx_ph_q <= tx_ph_d;
            tx_bit_q <= tx_bit_d;
            tx_sh_q <= tx_sh_d;
            tx_par_q <= tx_par_d;
            line_q <= txd_d && !cfg_q[CFG_BRK];
            txo_q <= loop || (txd_d && !cfg_q[CFG_BRK]);
        end
    end

    // ====
    // Receiver
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_BRK} asp_rx_e;
    asp_rx_e rx_st_q;
    asp_rx_e rx_st_d;
    logic [3:0] rx_ph_q;
    logic [3:0] rx_ph_d;
    logic [2:0] rx_bit_q;
    logic [2:0] rx_bit_d;
    logic [7:0] rx_sh_q;
    logic [7:0] rx_sh_d;
    logic rx_pb_q;
    logic rx_pb_d;
    logic pe_evt;
    logic fe_evt;
    logic bi_evt;

    wire rx_in = loop ? line_q : rxd_s2_q;
    wire rx_mid = tick && (rx_ph_q == END_PH);
    assign rx_char = align(rx_sh_q, len);

    always_comb begin
        rx_st_d = rx_st_q;
        rx_ph_d = tick ? rx_ph_q + 4'h1 : rx_ph_q;
        rx_bit_d = rx_bit_q;
        rx_sh_d = rx_sh_q;
        rx_pb_d = rx_pb_q;
        rx_push = 1'b0;
        pe_evt = 1'b0;
        fe_evt = 1'b0;
        bi_evt = 1'b0;
        unique case (rx_st_q)
            RX_IDLE: begin
                rx_ph_d = '0;
                if (tick && !rx_in) begin
                    rx_st_d = RX_START;
                end
            end
            RX_START: begin
                if (tick && (rx_ph_q == MID_PH)) begin
                    rx_ph_d = '0;
                    rx_bit_d = '0;
                    rx_pb_d = 1'b0;
                    rx_st_d = rx_in ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA: begin
                // Sixteen ticks after the start midpoint lands on each bit centre
                if (rx_mid) begin
                    rx_sh_d = {rx_in, rx_sh_q[7:1]};
                    rx_bit_d = rx_bit_q + 3'd1;
                    if (rx_bit_q == nbit_m1) begin
                        rx_st_d = pen ? RX_PAR : RX_STOP;
                    end
                end
            end
            RX_PAR: begin
                if (rx_mid) begin
                    rx_pb_d = rx_in;
                    pe_evt = rx_in != par_bit(rx_char, even);
                    rx_st_d = RX_STOP;
                end
            end
            RX_STOP: begin
                if (rx_mid) begin
                    rx_push = 1'b1;
                    fe_evt = !rx_in;
                    bi_evt = !rx_in && (rx_char == 8'h00) && !rx_pb_q;
                    rx_st_d = bi_evt ? RX_BRK : RX_IDLE;
                end
            end
            RX_BRK: begin
                // Wait for the break to end
                if (rx_in) begin
                    rx_st_d = RX_IDLE;
                end
            end
            default: begin
                rx_st_d = RX_IDLE;
            end
        endcase
    end

    always_ff @(posedge MCLK_I) begin
        if (RESET_I) begin
            rx_st_q <= RX_IDLE;
            rx_ph_q <= '0;
            rx_bit_q <= '0;
            rx_sh_q <= '0;
            rx_pb_q <= 1'b0;
        end else begin
            rx_st_q <= rx_st_d;
            rx_ph_q <= rx_ph_d;
            rx_bit_q <= rx_bit_d;
            rx_sh_q <= rx_sh_d;
            rx_pb_q <= rx_pb_d;
        end
    end

    // ====
    // Status, interrupt, DMA and flow outputs
    wire [ST_W-1:0] ev;
    assign ev[ST_RX] = rx_push && rxf_ready;
    assign ev[ST_TX] = tx_pop;
    assign ev[ST_PE] = pe_evt;
    assign ev[ST_FE] = fe_evt && !bi_evt;
    assign ev[ST_OE] = rx_push && !rxf_ready; // New character lost
    assign ev[ST_BI] = bi_evt;
    wire [ST_W-1:0] diag_set = wr_diag ? (WDATA_I[ST_W-1:0] & DIAG_MASK) : '0;
    wire [ST_W-1:0] stat_clr = wr_stat ? WDATA_I[ST_W-1:0] : '0;
    // Events win over a same-cycle clear
    assign stat_d = (stat_q & ~stat_clr) | ev | diag_set;

    always_ff @(posedge MCLK_I) begin
        if (RESET_I) begin
            stat_q <= '0;
            irq_q <= 1'b0;
            rts_n_q <= 1'b1;
            rx_dma_q <= 1'b0;
            tx_dma_q <= 1'b0;
        end else begin
            stat_q <= stat_d;
            irq_q <= |(stat_q & mask_q);
            rts_n_q <= afc && (rx_cnt >= trig);
            rx_dma_q <= rx_cnt >= trig;
            tx_dma_q <= txf_ready;
        end
    end

    // ====
    // Register port
    logic [REG_W-1:0] rd_mux;
    always_comb begin
        rd_mux = '0;
        unique case (ADDR_I)
            OFS_DATA: rd_mux = {8'h00, rxf_valid ? rxf_data : 8'h00};
            OFS_DIV: rd_mux = div_q;
            OFS_CFG: rd_mux = REG_W'(cfg_q);
            OFS_STAT: rd_mux = REG_W'(stat_q);
            OFS_MASK: rd_mux = REG_W'(mask_q);
            OFS_LEVEL: rd_mux = REG_W'({cts_s2_q, rts_n_q, 1'b0, tx_cnt, 3'b000, rx_cnt});
            default: rd_mux = '0;
        endcase
    end

    always_ff @(posedge MCLK_I) begin
        if (RESET_I) begin
            div_q <= DIV_RST;
            cfg_q <= CFG_RST;
            mask_q <= MASK_RST;
            rdata_q <= '0;
        end else begin
            if (wr_div) begin
                div_q <= WDATA_I;
            end
            if (wr_cfg) begin
                cfg_q <= WDATA_I[CFG_W-1:0];
            end
            if (wr_mask) begin
                mask_q <= WDATA_I[ST_W-1:0];
            end
            rdata_q <= RD_I ? rd_mux : '0;
        end
    end

    assign RDATA_O = rdata_q;
    assign TXD_O = txo_q;
    assign RTS_N_O = rts_n_q;
    assign IRQ_O = irq_q;
    assign RX_DMA_REQ_O = rx_dma_q;
    assign TX_DMA_REQ_O = tx_dma_q;
endmodule : asp_top

// ==== design/asp_pkg.sv ====
// Constants shared by the asynchronous serial port design
package asp_pkg;
    // ====
    // Sizes
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int ADDR_W = 3;
    localparam int REG_W = 16;
    localparam int CFG_W = 11;
    localparam int ST_W = 6;
    // ====
    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_DATA = 3'h0;
    localparam logic [ADDR_W-1:0] OFS_DIV = 3'h1;
    localparam logic [ADDR_W-1:0] OFS_CFG = 3'h2;
    localparam logic [ADDR_W-1:0] OFS_STAT = 3'h3;
    localparam logic [ADDR_W-1:0] OFS_MASK = 3'h4;
    localparam logic [ADDR_W-1:0] OFS_DIAG = 3'h5;
    localparam logic [ADDR_W-1:0] OFS_LEVEL = 3'h6;
    // ====
    // Configuration fields
    localparam int CFG_LEN_LO = 0;
    localparam int CFG_STOP2 = 2;
    localparam int CFG_PEN = 3;
    localparam int CFG_EVEN = 4;
    localparam int CFG_BRK = 5;
    localparam int CFG_LOOP = 6;
    localparam int CFG_FIFO = 7;
    localparam int CFG_TRIG_LO = 8;
    localparam int CFG_AFC = 10;
    // ====
    // Status, mask and diagnostic bits
    localparam int ST_RX = 0;
    localparam int ST_TX = 1;
    localparam int ST_PE = 2;
    localparam int ST_FE = 3;
    localparam int ST_OE = 4;
    localparam int ST_BI = 5;
    localparam logic [ST_W-1:0] DIAG_MASK = 6'h3C;
    // ====
    // Reset values
    localparam logic [REG_W-1:0] DIV_RST = 16'h0001;
    localparam logic [CFG_W-1:0] CFG_RST = 11'h083;
    localparam logic [ST_W-1:0] MASK_RST = 6'h00;
    // ====
    // Bit timing in sixteenth-bit ticks
    localparam int OVS = 16;
    localparam logic [3:0] MID_PH = 4'h7;
    localparam logic [3:0] END_PH = 4'hF;
    localparam logic [4:0] STOP1_LAST = 5'h0F;
    localparam logic [4:0] STOP15_LAST = 5'h17;
    localparam logic [4:0] STOP2_LAST = 5'h1F;
    // Trigger levels of the receive queue
    localparam logic [4:0] TRIG_1 = 5'h01;
    localparam logic [4:0] TRIG_4 = 5'h04;
    localparam logic [4:0] TRIG_8 = 5'h08;
    localparam logic [4:0] TRIG_14 = 5'h0E;
endpackage : asp_pkg

// ==== design/asp_fifo.sv ====
// Character queue with a run-time fill limit
`timescale 1ns/1ps
module asp_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 16,
    localparam int CW = $clog2(DEPTH + 1),
    localparam int AW = $clog2(DEPTH)
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [CW-1:0] lim_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o,
    output logic [CW-1:0] count_o
);
    if ((DEPTH < 2) || ((DEPTH & (DEPTH - 1)) != 0)) begin : g_chk
        $error("asp_fifo: DEPTH must be a power of two of at least 2");
    end

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [CW-1:0] cnt_q;
    wire do_push = in_valid_i && in_ready_o;
    wire do_pop = out_valid_o && out_ready_i;

    // A limit of one gives single-character holding
    assign in_ready_o = cnt_q < lim_i;
    assign out_valid_o = cnt_q != '0;
    assign out_data_o = mem[rd_q];
    assign count_o = cnt_q;

    always_ff @(posedge clk_i) begin
        if (do_push) begin
            mem[wr_q] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_q + AW'(do_push);
            rd_q <= rd_q + AW'(do_pop);
            cnt_q <= cnt_q + CW'(do_push) - CW'(do_pop);
        end
    end
endmodule : asp_fifo

// ==== bench/asp_checker.sv ====
// Assertions on the serial port's register port and line
`timescale 1ns/1ps
module asp_checker
    import asp_pkg::*;
(
    input wire logic MCLK_I,
    input wire logic RESET_I,
    input wire logic [ADDR_W-1:0] ADDR_I,
    input wire logic [REG_W-1:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [REG_W-1:0] RDATA_O,
    input wire logic TXD_O,
    input wire logic RTS_N_O,
    input wire logic IRQ_O,
    input wire logic RX_DMA_REQ_O
);
    // ====
    // Shadow settings
    logic [CFG_W-1:0] cfg_q;
    logic [REG_W-1:0] div_q;
    logic [ST_W-1:0] mask_q;
    logic rd_q;
    logic [ADDR_W-1:0] ra_q;
    int low_q;
    int bdiv;
    assign bdiv = (div_q == 0) ? 16 : 16 * int'(div_q);
    always_ff @(posedge MCLK_I) begin
        rd_q <= RD_I && !RESET_I;
        ra_q <= ADDR_I;
        // Current low stretch
        low_q <= TXD_O ? 0 : low_q + 1;
        if (RESET_I) begin
            cfg_q <= CFG_RST;
            div_q <= DIV_RST;
            mask_q <= MASK_RST;
        end else if (WR_I) begin
            cfg_q <= (ADDR_I == OFS_CFG) ? WDATA_I[CFG_W-1:0] : cfg_q;
            div_q <= (ADDR_I == OFS_DIV) ? WDATA_I : div_q;
            mask_q <= (ADDR_I == OFS_MASK) ? WDATA_I[ST_W-1:0] : mask_q;
        end
    end
    // ====
    // Properties
    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (RESET_I);
    property p_rd_idle;
        !rd_q |-> RDATA_O == '0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_div_rb;
        rd_q && ra_q == OFS_DIV |-> RDATA_O == div_q;
    endproperty
    a_div_rb: assert property (p_div_rb) else $error("divisor readback wrong");
    property p_unmap;
        rd_q && (ra_q == 3'h7 || ra_q == OFS_DIAG) |-> RDATA_O == '0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("write-only place read nonzero");
    property p_irq_off;
        mask_q == 0 && $past(mask_q) == 0 |-> !IRQ_O;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("interrupt with all masked");
    property p_brk;
        cfg_q[CFG_BRK] && $past(cfg_q[CFG_BRK]) && !cfg_q[CFG_LOOP] |-> !TXD_O;
    endproperty
    a_brk: assert property (p_brk) else $error("break not held low");
    property p_loop;
        cfg_q[CFG_LOOP] && $past(cfg_q[CFG_LOOP]) && !cfg_q[CFG_BRK] |-> TXD_O;
    endproperty
    a_loop: assert property (p_loop) else $error("line moved in loopback");
    property p_rts_off;
        !cfg_q[CFG_AFC] && !$past(cfg_q[CFG_AFC]) && !$past(RESET_I) |-> !RTS_N_O;
    endproperty
    a_rts_off: assert property (p_rts_off) else $error("request to send dropped");
    property p_rts_dma;
        cfg_q[CFG_AFC] && $past(cfg_q[CFG_AFC]) |-> RTS_N_O == RX_DMA_REQ_O;
    endproperty
    a_rts_dma: assert property (p_rts_dma) else $error("flow stop off threshold");
    // Low stretches are whole bits
    property p_bit;
        $rose(TXD_O) && !$past(cfg_q[CFG_BRK], 2) |-> low_q % bdiv == 0;
    endproperty
    a_bit: assert property (p_bit) else $error("low stretch not whole bits");
    c_irq: cover property ($rose(IRQ_O));
    c_rts: cover property (cfg_q[CFG_AFC] && $rose(RTS_N_O));
    c_brk: cover property (cfg_q[CFG_BRK] && !TXD_O);
endmodule : asp_checker

bind asp_top asp_checker u_chk (.MCLK_I(MCLK_I), .RESET_I(RESET_I), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .TXD_O(TXD_O),
    .RTS_N_O(RTS_N_O), .IRQ_O(IRQ_O), .RX_DMA_REQ_O(RX_DMA_REQ_O));

// ==== bench/asp_peer.sv ====
// Far-side serial peer: sends frames on demand and decodes received frames
`timescale 1ns/1ps
module asp_peer (
    input wire logic clk_i,
    input wire logic txd_i,
    input wire logic rts_n_i,
    output logic rxd_o,
    output logic cts_n_o
);
    int bt = 16;
    int len = 8;
    bit pen;
    bit even;
    logic [15:0] got[$];
    initial begin
        rxd_o = 1'b1;
        cts_n_o = 1'b0;
    end
    // ====
    // Sender; kind 1 bad parity, 2 bad stop, 3 short start, 4 break
    task automatic send(input logic [7:0] d, input int kind);
        int w;
        w = 0;
        while (rts_n_i && w < 20000) begin
            @(posedge clk_i);
            w++;
        end
        rxd_o <= 1'b0;
        if (kind == 3) begin
            repeat (bt / 4) @(posedge clk_i);
        end else begin
            repeat (bt) @(posedge clk_i);
            for (int i = 0; i < len; i++) begin
                rxd_o <= (kind != 4) && d[i];
                repeat (bt) @(posedge clk_i);
            end
            if (pen) begin
                rxd_o <= (kind != 4) && ((^(d & 8'((1 << len) - 1)) ^ !even) ^ (kind == 1));
                repeat (bt) @(posedge clk_i);
            end
            rxd_o <= kind < 2;
            repeat (bt) @(posedge clk_i);
        end
        rxd_o <= 1'b1;
        repeat (bt * 2) @(posedge clk_i);
    endtask : send
    // ====
    // Receiver, sampling each bit mid-way
    always begin
        logic [15:0] v;
        @(negedge txd_i);
        v = '0;
        repeat (bt / 2) @(posedge clk_i);
        for (int i = 0; i <= len + pen + 1; i++) begin
            if (i > 0) repeat (bt) @(posedge clk_i);
            v[i] = txd_i;
        end
        got.push_back(v);
    end
endmodule : asp_peer

// ==== bench/tb.sv ====
// Self-checking bench for the serial port
`timescale 1ns/1ps
module tb
    import asp_pkg::*;
;
    logic clk, rst, wr, rd, txd, rts_n, irq, rxq, txq, rxd, cts_n;
    logic [2:0] addr;
    logic [15:0] wdata, rdata, v, d;
    logic [15:0] q[$];
    logic [15:0] stx[5] = '{16'h01, 16'h05, 16'h09, 16'h00, 16'h21};
    int lv[4] = '{1, 4, 8, 14};
    int miscompares, total_checks, n;
    always #5 clk = ~clk;
    asp_top dut (.MCLK_I(clk), .RESET_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
        .RD_I(rd), .RDATA_O(rdata), .RXD_I(rxd), .TXD_O(txd), .CTS_N_I(cts_n),
        .RTS_N_O(rts_n), .IRQ_O(irq), .RX_DMA_REQ_O(rxq), .TX_DMA_REQ_O(txq));
    asp_peer peer (.clk_i(clk), .txd_i(txd), .rts_n_i(rts_n), .rxd_o(rxd), .cts_n_o(cts_n));
    // ====
    // Helpers
    function automatic logic [15:0] fexp(input logic [15:0] x, input int l, input bit p, ev);
        logic [15:0] m;
        m = x & 16'((1 << l) - 1);
        return (m << 1) | 16'((p ? (^m ^ !ev) : 1'b1) << (l + 1)) | 16'(1 << (l + p + 1));
    endfunction : fexp
    task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim
    task automatic guard;
        @(posedge clk);
        n++;
        if (n > 10000) begin
            $display("MISMATCH wait bound exceeded");
            miscompares++;
            end_sim();
        end
    endtask : guard
    task automatic wr_r(input logic [2:0] a, input logic [15:0] x);
        addr <= a;
        wdata <= x;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask : wr_r
    task automatic rd_r(input logic [2:0] a);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        v = rdata;
    endtask : rd_r
    task automatic wait_rx;
        n = 0;
        rd_r(OFS_STAT);
        while (v[ST_RX] !== 1'b1) begin
            guard();
            rd_r(OFS_STAT);
        end
    endtask : wait_rx
    task automatic wait_got(input int c);
        n = 0;
        while (peer.got.size() < c) guard();
    endtask : wait_got
    // ====
    // Main sequence
    initial begin
        clk = 0;
        rst = 1;
        addr = 0;
        wdata = 0;
        wr = 0;
        rd = 0;
        void'($urandom(32'h7acf));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd_r(OFS_DIV);
        chk("div reset", DIV_RST, v);
        rd_r(OFS_CFG);
        chk("cfg reset", 16'(CFG_RST), v);
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            d = 16'($urandom);
            wr_r(OFS_DIV, 16'(i % 3 + 1));
            wr_r(OFS_CFG, 16'h00C0 | 16'(i) | (d & 16'h0010));
            wr_r(OFS_DATA, d);
            wait_rx();
            rd_r(OFS_DATA);
            chk("loop char", d & ((16'h1 << (i % 4 + 5)) - 1), v);
            rd_r(OFS_STAT);
            chk("loop errors", 0, v & 16'h3C);
            wr_r(OFS_STAT, 16'h3F);
        end
        $display("test loopback done");
        peer.bt = 32;
        peer.pen = 1;
        peer.even = 1;
        wr_r(OFS_DIV, 16'h2);
        wr_r(OFS_CFG, 16'h009B);
        for (int i = 0; i < 3; i++) begin
            q.push_back(16'($urandom) & 16'h00FF);
            wr_r(OFS_DATA, q[i]);
        end
        wait_got(3);
        for (int i = 0; i < 3; i++) chk("tx frame", fexp(q[i], 8, 1, 1), peer.got[i]);
        for (int k = 0; k < 5; k++) begin
            d = 16'($urandom | 1);
            peer.send(d[7:0], k);
            rd_r(OFS_STAT);
            chk("rx status", stx[k], v & 16'h3D);
            rd_r(OFS_DATA);
            if (k == 0) chk("rx char", d & 16'h00FF, v);
            wr_r(OFS_STAT, 16'h3F);
        end
        $display("test line done");
        wr_r(OFS_MASK, 16'h0001);
        peer.send(8'h5A, 0);
        chk("irq set", 1, irq);
        wr_r(OFS_DIAG, 16'h003C);
        rd_r(OFS_STAT);
        chk("forced errors", 16'h3D, v);
        wr_r(OFS_STAT, 16'h0001);
        @(posedge clk) chk("irq masked", 0, irq);
        wr_r(OFS_MASK, 16'h003C);
        @(posedge clk) chk("irq forced", 1, irq);
        wr_r(OFS_STAT, 16'h3F);
        @(posedge clk) chk("irq cleared", 0, irq);
        rd_r(OFS_DATA);
        $display("test interrupt done");
        peer.pen = 0;
        peer.got.delete();
        q.delete();
        peer.cts_n_o <= 1'b1;
        wr_r(OFS_CFG, 16'h0483);
        for (int i = 0; i < 17; i++) begin
            q.push_back(16'($urandom) & 16'h00FF);
            wr_r(OFS_DATA, q[i]);
        end
        rd_r(OFS_LEVEL);
        chk("tx full", 16'h10, 16'(v[12:8]));
        chk("tx dma full", 0, txq);
        peer.cts_n_o <= 1'b0;
        wait_got(16);
        for (int i = 0; i < 16; i++) chk("queued frame", fexp(q[i], 8, 0, 0), peer.got[i]);
        for (int t = 0; t < 4; t++) begin
            wr_r(OFS_CFG, 16'h0483 | 16'(t << 8));
            for (int j = 1; j < lv[t]; j++) peer.send(8'($urandom), 0);
            chk("rx dma below", 0, rxq);
            peer.send(8'($urandom), 0);
            chk("rx dma at", 1, rxq);
            chk("rts at", 1, rts_n);
            for (int j = 0; j < lv[t]; j++) rd_r(OFS_DATA);
        end
        $display("test queues done");
        wr_r(OFS_CFG, 16'h0003);
        peer.send(8'h11, 0);
        peer.send(8'h22, 0);
        rd_r(OFS_STAT);
        chk("overrun", 16'h10, v & 16'h10);
        rd_r(OFS_LEVEL);
        chk("single hold", 16'h1, 16'(v[4:0]));
        wr_r(OFS_CFG, 16'h00A3);
        @(posedge clk) chk("break line", 0, txd);
        $display("test holding and break done");
        end_sim();
    end
endmodule : tb
